/* File: rtl/rlsrq_params.svh */
// constants for the remote/local and service-request front end
`ifndef RLSRQ_PARAMS_SVH
`define RLSRQ_PARAMS_SVH
`define RLSRQ_BIT_LOCK_LOST  0
`define RLSRQ_BIT_LOCK_GOT   1
`define RLSRQ_BIT_BAD_CMD    2
`define RLSRQ_BIT_RQS        7
`define RLSRQ_ADDR_STATUS    4'h0
`define RLSRQ_ADDR_MASK      4'h1
`define RLSRQ_ADDR_SETTINGS  4'h2
`define RLSRQ_ADDR_RL        4'h3
`define RLSRQ_MASK_RST       8'h00
`define RLSRQ_CODE_MASK      8'h40
`define RLSRQ_FILTER_DEF     2'h1
`define RLSRQ_BW_DEF         3'h1
`define RLSRQ_MODE_DEF       2'h0
`define RLSRQ_CAPTURE_DEF    1'b0
`endif

/* File: rtl/rlsrq_pkg.sv */
// types for the remote/local and service-request front end
package rlsrq_pkg;
  typedef enum logic [2:0] {
    RL_LOCAL  = 3'b001,
    RL_REMOTE = 3'b010,
    RL_LOCKED = 3'b100
  } rlsrq_state_e;
endpackage

/* File: rtl/rlsrq_top.sv */
// remote/local state, device clear defaults, status byte and service request
// Notes on behaviour
// - all front-panel settings also bus-programmable
// - group execute trigger does nothing
// - device clear restores default instrument settings
// - remote only while REN asserted
// - remote entered on first listen addressing
// - remote indicator lit exactly in remote
// - GTL or local key returns to local
// - lockout blocks the local key, controller only
// - REN false forces local, clears lockout
// - no controller function, take-control ignored
// - SRQ on masked condition events
// - serial poll byte, bit 7 pending request
// - status bits latched until gone and read
// - byte after mask code becomes mask
`timescale 1ns/1ns
`include "rlsrq_params.svh"
module rlsrq_top
  import rlsrq_pkg::*;
(
  input  wire logic       CLK,
  input  wire logic       RST_B,
  input  wire logic       REN,
  input  wire logic       LISTEN_ADDR,
  input  wire logic       GTL_CMD,
  input  wire logic       LLO_CMD,
  input  wire logic       DCL_CMD,
  input  wire logic       GET_CMD,
  input  wire logic       TCT_CMD,
  input  wire logic       DATA_STB,
  input  wire logic [7:0] DATA_BYTE,
  input  wire logic       BAD_CMD,
  input  wire logic       SPOLL_RD,
  input  wire logic       LOCK_IN,
  input  wire logic       KEY_LOCAL,
  input  wire logic       KEY_STB,
  input  wire logic [7:0] KEY_DATA,
  input  wire logic [3:0] ADDR,
  input  wire logic [7:0] WDATA,
  input  wire logic       WR,
  input  wire logic       RD,
  output logic      [7:0] RDATA,
  output logic      [7:0] STATUS_BYTE,
  output logic            SRQ,
  output logic            REMOTE_LED,
  output logic            LOCKOUT,
  output logic      [1:0] FILTER_SEL,
  output logic      [2:0] PLL_BW,
  output logic      [1:0] MEAS_MODE,
  output logic            CAPTURE
);
  // three-stage sampling of the asynchronous pins
  logic [2:0] ren_s_r, lis_s_r, lock_s_r;
  logic       ren_q_r, lis_q_r, lock_q_r;
  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      ren_s_r  <= 3'h0;
      lis_s_r  <= 3'h0;
      lock_s_r <= 3'h0;
      ren_q_r  <= 1'b0;
      lis_q_r  <= 1'b0;
      lock_q_r <= 1'b0;
    end else begin
      ren_s_r  <= {ren_s_r[1:0], REN};
      lis_s_r  <= {lis_s_r[1:0], LISTEN_ADDR};
      lock_s_r <= {lock_s_r[1:0], LOCK_IN};
      if (ren_s_r[1] == ren_s_r[2]) ren_q_r <= ren_s_r[2];
      if (lis_s_r[1] == lis_s_r[2]) lis_q_r <= lis_s_r[2];
      if (lock_s_r[1] == lock_s_r[2]) lock_q_r <= lock_s_r[2];
    end
  end

  rlsrq_state_e st_r, st_nxt;
  logic         lls_r, lls_nxt;
  logic         lis_d_r, lock_d_r;
  logic         lis_rise;
  assign lis_rise = lis_q_r & ~lis_d_r;

  always_comb begin
    st_nxt  = st_r;
    lls_nxt = lls_r;
    if (!ren_q_r) begin
      st_nxt  = RL_LOCAL;
      lls_nxt = 1'b0;
    end else begin
      if (LLO_CMD) lls_nxt = 1'b1;
      unique case (st_r)
        RL_LOCAL: begin
          if (lis_rise) st_nxt = (LLO_CMD | lls_r) ? RL_LOCKED : RL_REMOTE;
        end
        RL_REMOTE: begin
          if (GTL_CMD || (KEY_LOCAL && !lls_r && !LLO_CMD)) st_nxt = RL_LOCAL;
          else if (LLO_CMD) st_nxt = RL_LOCKED;
        end
        RL_LOCKED: begin
          if (GTL_CMD) st_nxt = RL_LOCAL;
        end
        default: st_nxt = RL_LOCAL;
      endcase
    end
  end

  // settings: bus data and front-panel keys share one set of fields
  logic [7:0] mask_r, mask_nxt;
  logic       mask_arm_r, mask_arm_nxt;
  logic [1:0] filt_r, filt_nxt;
  logic [2:0] bw_r, bw_nxt;
  logic [1:0] mode_r, mode_nxt;
  logic       cap_r, cap_nxt;
  logic       keys_ok;
  logic       wr_set;
  logic [7:0] set_val;
  // keys act only in local; GET and TCT have no effect at all
  assign keys_ok = (st_r == RL_LOCAL) && KEY_STB;
  assign wr_set  = WR && (ADDR == `RLSRQ_ADDR_SETTINGS);

  always_comb begin
    mask_nxt     = mask_r;
    mask_arm_nxt = mask_arm_r;
    filt_nxt     = filt_r;
    bw_nxt       = bw_r;
    mode_nxt     = mode_r;
    cap_nxt      = cap_r;
    set_val      = wr_set ? WDATA : KEY_DATA;
    if (DATA_STB) begin
      if (mask_arm_r) begin
        mask_nxt     = DATA_BYTE;
        mask_arm_nxt = 1'b0;
      end else if (DATA_BYTE == `RLSRQ_CODE_MASK) begin
        mask_arm_nxt = 1'b1;
      end
    end
    if (WR && ADDR == `RLSRQ_ADDR_MASK) mask_nxt = WDATA;
    if (wr_set || keys_ok) begin
      filt_nxt = set_val[1:0];
      bw_nxt   = set_val[4:2];
      mode_nxt = set_val[6:5];
      cap_nxt  = set_val[7];
    end
    if (DCL_CMD) begin
      filt_nxt = `RLSRQ_FILTER_DEF;
      bw_nxt   = `RLSRQ_BW_DEF;
      mode_nxt = `RLSRQ_MODE_DEF;
      cap_nxt  = `RLSRQ_CAPTURE_DEF;
    end
  end

  // status conditions: latched, cleared by a poll read once the cause is gone
  logic [2:0] cond_r, cond_nxt, cause;
  logic       rd_r, rd_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic [7:0] sbyte;
  logic       rqs;
  assign cause = {BAD_CMD, lock_q_r & ~lock_d_r, ~lock_q_r & lock_d_r};
  assign rqs   = |({cond_r[2], cond_r[1], cond_r[0]} & {mask_r[2], mask_r[1], mask_r[0]});
  always_comb begin
    sbyte = 8'h00;
    sbyte[`RLSRQ_BIT_RQS]       = rqs;
    sbyte[`RLSRQ_BIT_BAD_CMD]   = cond_r[2];
    sbyte[`RLSRQ_BIT_LOCK_GOT]  = cond_r[1];
    sbyte[`RLSRQ_BIT_LOCK_LOST] = cond_r[0];
  end

  always_comb begin
    cond_nxt = cond_r;
    if (SPOLL_RD || (RD && ADDR == `RLSRQ_ADDR_STATUS)) begin
      // lock bits persist while the lock state still matches
      cond_nxt[2] = 1'b0;
      cond_nxt[1] = cond_r[1] & lock_q_r;
      cond_nxt[0] = cond_r[0] & ~lock_q_r;
    end
    cond_nxt = cond_nxt | cause;  // a new event beats the clear
    rd_nxt    = RD;
    rdata_nxt = 8'h00;
    unique case (ADDR)
      `RLSRQ_ADDR_STATUS:   rdata_nxt = sbyte;
      `RLSRQ_ADDR_MASK:     rdata_nxt = mask_r;
      `RLSRQ_ADDR_SETTINGS: rdata_nxt = {cap_r, mode_r, bw_r, filt_r};
      `RLSRQ_ADDR_RL:       rdata_nxt = {5'h00, lls_r, st_r == RL_LOCKED, st_r != RL_LOCAL};
      default:              rdata_nxt = 8'h00;
    endcase
    if (!RD) rdata_nxt = 8'h00;
  end

  always_ff @(posedge CLK or negedge RST_B) begin
    if (!RST_B) begin
      st_r       <= RL_LOCAL;
      lls_r      <= 1'b0;
      lis_d_r    <= 1'b0;
      lock_d_r   <= 1'b0;
      mask_r     <= `RLSRQ_MASK_RST;
      mask_arm_r <= 1'b0;
      filt_r     <= `RLSRQ_FILTER_DEF;
      bw_r       <= `RLSRQ_BW_DEF;
      mode_r     <= `RLSRQ_MODE_DEF;
      cap_r      <= `RLSRQ_CAPTURE_DEF;
      cond_r     <= 3'h0;
      rd_r       <= 1'b0;
      rdata_r    <= 8'h00;
    end else begin
      st_r       <= st_nxt;
      lls_r      <= lls_nxt;
      lis_d_r    <= lis_q_r;
      lock_d_r   <= lock_q_r;
      mask_r     <= mask_nxt;
      mask_arm_r <= mask_arm_nxt;
      filt_r     <= filt_nxt;
      bw_r       <= bw_nxt;
      mode_r     <= mode_nxt;
      cap_r      <= cap_nxt;
      cond_r     <= cond_nxt;
      rd_r       <= rd_nxt;
      rdata_r    <= rdata_nxt;
    end
  end

  assign RDATA       = rdata_r;
  assign STATUS_BYTE = sbyte;
  assign SRQ         = rqs;
  assign REMOTE_LED  = (st_r != RL_LOCAL);
  assign LOCKOUT     = lls_r;
  assign FILTER_SEL  = filt_r;
  assign PLL_BW      = bw_r;
  assign MEAS_MODE   = mode_r;
  assign CAPTURE     = cap_r;
endmodule // rlsrq_top

/* File: tb/rlsrq_ctl.sv */
// bus controller model: remote enable, listen addressing, commands, data bytes
`timescale 1ns/1ns
module rlsrq_ctl (
  input  logic       clk,
  output logic       ren,
  output logic       listen,
  output logic [4:0] cmd,
  output logic       stb,
  output logic [7:0] dbyte
);
  initial {ren, listen, cmd, stb, dbyte} = 16'h0000;
  // cmd is {tct, get, dcl, llo, gtl}; take-control only when a test asks
  task automatic pulse(input logic [4:0] c);
    @(posedge clk) cmd <= c;
    @(posedge clk) cmd <= 5'h00;
  endtask
  // mask follows its code at once; released bus shows no stale byte
  task automatic send(input logic [7:0] b);
    @(posedge clk) {stb, dbyte} <= {1'h1, b};
    @(posedge clk) {stb, dbyte} <= {1'h0, ~b};
  endtask
  task automatic rl(input logic r, input logic l);  // set ren and listen levels, then wait six cycles
    @(posedge clk) {ren, listen} <= {r, l};
    repeat (6) @(posedge clk);
  endtask
endmodule // rlsrq_ctl

/* File: tb/rlsrq_monitor.sv */
// assertions on the remote/local front end, bound to its top module
`timescale 1ns/1ns
module rlsrq_monitor (
  input logic       CLK,
  input logic       RST_B,
  input logic       DCL_CMD,
  input logic       GTL_CMD,
  input logic       WR,
  input logic       RD,
  input logic [3:0] ADDR,
  input logic       BAD_CMD,
  input logic       KEY_STB,
  input logic       KEY_LOCAL,
  input logic [7:0] RDATA,
  input logic [7:0] STATUS_BYTE,
  input logic       SRQ,
  input logic       REMOTE_LED,
  input logic       LOCKOUT,
  input logic [1:0] FILTER_SEL,
  input logic [2:0] PLL_BW,
  input logic [1:0] MEAS_MODE,
  input logic       CAPTURE
);
  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_B);
  wire [7:0] cfg = {CAPTURE, MEAS_MODE, PLL_BW, FILTER_SEL};
  chk_srq_rqs: assert property (SRQ == STATUS_BYTE[7]) else $error("srq");
  chk_dcl_default: assert property (DCL_CMD |=> cfg == 8'h05) else $error("clear");
  chk_gtl_local: assert property (GTL_CMD |=> !REMOTE_LED) else $error("gtl");
  chk_key_blocked:
    assert property (REMOTE_LED && KEY_STB && !WR && !DCL_CMD |=> $stable(cfg)) else $error("key");
  chk_lockout_key:
    assert property (LOCKOUT && REMOTE_LED && KEY_LOCAL |=> REMOTE_LED) else $error("lockout");
  chk_bad_cmd: assert property (BAD_CMD |=> STATUS_BYTE[2]) else $error("bad cmd");
  chk_poll_byte:
    assert property (RD && ADDR == 4'h0 |=> RDATA == $past(STATUS_BYTE)) else $error("poll");
  chk_reset_idle:
    assert property ($rose(RST_B) |-> !SRQ && !REMOTE_LED && !LOCKOUT) else $error("reset");
endmodule // rlsrq_monitor

bind rlsrq_top rlsrq_monitor u_rlsrq_monitor (.*);

/* File: tb/tb.sv */
// self-checking bench for the remote/local and service-request front end
`timescale 1ns/1ns
module tb;
  logic       CLK = 0, RST_B = 0, BAD_CMD = 0, LOCK_IN = 0, KEY_LOCAL = 0, KEY_STB = 0;
  logic       WR = 0, RD = 0, SRQ, REMOTE_LED, LOCKOUT, CAPTURE, REN, LISTEN_ADDR, DATA_STB;
  logic [7:0] KEY_DATA = 0, WDATA = 0, RDATA, STATUS_BYTE, DATA_BYTE, r, es = 8'h05, em = 0;
  logic [3:0] ADDR = 0;
  logic [1:0] FILTER_SEL, MEAS_MODE;
  logic [2:0] PLL_BW, ec = 0;
  logic [4:0] cmd;
  logic       er = 0, el = 0, SPOLL_RD = 0;
  int         n_errors = 0, comparisons = 0;
  rlsrq_ctl u_rlsrq_ctl (.clk(CLK), .ren(REN), .listen(LISTEN_ADDR), .cmd(cmd), .stb(DATA_STB),
    .dbyte(DATA_BYTE));
  rlsrq_top u_rlsrq_top (.*, .GTL_CMD(cmd[0]), .LLO_CMD(cmd[1]), .DCL_CMD(cmd[2]),
    .GET_CMD(cmd[3]), .TCT_CMD(cmd[4]));
  always #4 CLK = ~CLK;
  task automatic cmp(input logic [17:0] got, input logic [17:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // synchronisers need a few cycles before the state is settled
  task automatic st;
    repeat (8) @(posedge CLK);
    #1 cmp({STATUS_BYTE, REMOTE_LED, LOCKOUT, CAPTURE, MEAS_MODE, PLL_BW, FILTER_SEL},
           {|(ec & em[2:0]), 4'h0, ec, er, el, es});
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge CLK) {ADDR, WDATA, WR} <= {a, d, 1'h1};
    @(posedge CLK) WR <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] e);
    @(posedge CLK) {ADDR, RD} <= {a, 1'h1};
    @(posedge CLK) RD <= 1'h0;
    #1 cmp(RDATA, e);
  endtask
  task automatic fp(input int k, input logic [7:0] d);  // 0 key, 1 local key, 2 bad command
    @(posedge CLK) {BAD_CMD, KEY_LOCAL, KEY_STB, KEY_DATA} <= {k == 2, k == 1, k == 0, d};
    @(posedge CLK) {BAD_CMD, KEY_LOCAL, KEY_STB} <= 3'h0;
  endtask
  task automatic wrap_up;
    $display("n_errors=%0d comparisons=%0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask
  initial begin
    void'($urandom(88253));
    repeat (16) @(posedge CLK);
    #2 RST_B = 1;
    st;
    rd(4'h3, 8'h00);
    rd(4'hF, 8'h00);
    r = $urandom;
    wr(4'h2, r);
    rd(4'h2, r);
    r = $urandom;
    fp(0, r);
    es = r;
    u_rlsrq_ctl.rl(1, 0);
    st;
    u_rlsrq_ctl.rl(1, 1);
    er = 1;
    st;
    fp(0, ~es);
    u_rlsrq_ctl.pulse(5'h18);
    st;
    fp(1, 8'h00);
    er = 0;
    st;
    u_rlsrq_ctl.rl(1, 0);
    u_rlsrq_ctl.rl(1, 1);
    u_rlsrq_ctl.pulse(5'h01);
    st;
    u_rlsrq_ctl.pulse(5'h02);
    u_rlsrq_ctl.rl(1, 0);
    u_rlsrq_ctl.rl(1, 1);
    fp(1, 8'h00);
    {er, el} = 2'h3;
    st;
    u_rlsrq_ctl.rl(0, 0);
    {er, el} = 2'h0;
    st;
    u_rlsrq_ctl.pulse(5'h04);
    es = 8'h05;
    st;
    for (int i = 0; i < 2; i++) begin
      u_rlsrq_ctl.send(8'h40);
      em = i ? 8'($urandom) : 8'h07;
      u_rlsrq_ctl.send(em);
      fp(2, 8'h00);
      @(posedge CLK) LOCK_IN <= 1'h1;
      ec[2:1] = 2'h3;
      st;
      @(posedge CLK) LOCK_IN <= 1'h0;
      ec[0] = 1;
      st;
      rd(4'h0, {|(ec & em[2:0]), 4'h0, ec});
      ec = 3'h1;
      st;
    end
    // lock regained: loss bit's cause is gone, a serial poll clears it
    @(posedge CLK) LOCK_IN <= 1'h1;
    ec = 3'h3;
    st;
    @(posedge CLK) SPOLL_RD <= 1'h1;
    @(posedge CLK) SPOLL_RD <= 1'h0;
    ec = 3'h2;
    st;
    wrap_up;
  end
  // whole run is a few hundred cycles; this limit is far beyond it
  initial begin
    #400000;
    n_errors++;
    wrap_up;
  end
endmodule // tb
